// ==== rtl/charger_regs_pkg.sv ====
// Purpose: shared constants and types for the charger control and status registers
// Assumes: registers are byte wide and reached over the two-wire serial port
// Notes:   device address is arbitrary and must be set per board
package charger_regs_pkg;

    // register offsets on the serial port
    localparam logic [7:0] ADDR_CFG         = 8'h1a;
    localparam logic [7:0] ADDR_STAT        = 8'h1b;
    localparam logic [7:0] ADDR_GPIO_THREE_AND_CHARGE_VOLTAGE_SAFETY       = 8'h1c;

    // reset values: full charge current and charging on by default
    localparam logic [7:0] CFG_RESET        = 8'h58;
    localparam logic [7:0] GPIO_THREE_AND_CHARGE_VOLTAGE_SAFETY_RESET      = 8'h00;
    localparam logic       CE_DEFAULT       = 1'b0;
    localparam logic       LATCH_RESET      = 1'b0;

    // field positions
    localparam int         BIT_SAFETY       = 4;

    // arbitrary neutral bus address
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

    // charge state codes
    localparam logic [1:0] ST_PRE           = 2'h0;
    localparam logic [1:0] ST_DONE          = 2'h1;
    localparam logic [1:0] ST_FAST          = 2'h2;
    localparam logic [1:0] ST_OFF           = 2'h3;

    // bus framing
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
    localparam logic [3:0] LAST_TX_BIT      = 4'h7;

    typedef struct packed {
        logic       charge_voltage_select;
        logic       charge_run;
        logic       term_disable;
        logic [1:0] charge_current_scale;
        logic       usb_current_limit_select;
        logic       input_limit_max;
        logic       system_from_input;
    } cfg_s;

    typedef struct packed {
        logic supplement_flag;
        logic selected_input_flag;
        logic loop_active_flag;
        logic wall_input_present;
        logic usb_input_present;
        logic charge_state_hi;
        logic charge_state_lo;
        logic input_overvoltage_flag;
    } stat_s;

    // analog comparator and charger core levels, asynchronous to i_clk
    typedef struct packed {
        logic sup_enter;      // battery above output by the entry margin
        logic sup_exit;       // battery above output by less than the exit margin
        logic selected_input_flag;
        logic loop_active_flag;
        logic wall_input_present;
        logic usb_input_present;
        logic input_overvoltage_flag;
        logic out_uvlo;
        logic precharge;
        logic done;
        logic fast;
        logic fault;
    } sense_s;

    typedef enum logic [3:0] {
        SER_IDLE   = 4'h0,
        SER_ADDR   = 4'h1,
        SER_AACK   = 4'h2,
        SER_REG    = 4'h3,
        SER_RACKW  = 4'h4,
        SER_WDATA  = 4'h5,
        SER_WACK   = 4'h6,
        SER_RDATA  = 4'h7,
        SER_MACK   = 4'h8
    } ser_state_e;

endpackage

// ==== rtl/serial_reg_port.sv ====
// Purpose: two-wire serial slave giving byte access to a small register file
// Assumes: serial clock well below i_clk / 4; lines are synchronised here
// Notes:   pointer auto-increments after each data byte
module serial_reg_port
    import charger_regs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_clk_en,
    // serial pins
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_oe,
    // register side
    input  wire logic [7:0] i_rdata,
    output logic [7:0]      o_ptr,
    output logic [7:0]      o_wdata,
    output logic            o_wr
);
    logic [1:0]  scl_m, sda_m;
    logic        scl_s, sda_s, scl_d, sda_d;
    logic [7:0]  sh, tx;
    logic [3:0]  cnt;
    logic        rw, nack;
    ser_state_e  state;
    logic        start, stop, rise, fall;

    // two-stage synchronisers; only stage two feeds the edge detect
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            scl_m <= 2'h3;
            sda_m <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (i_clk_en) begin
            scl_m <= {scl_m[0], i_scl};
            sda_m <= {sda_m[0], i_sda};
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end
    assign scl_s = scl_m[1];
    assign sda_s = sda_m[1];

    // bus conditions
    assign start = scl_s && scl_d && sda_d && !sda_s;
    assign stop  = scl_s && scl_d && !sda_d && sda_s;
    assign rise  = scl_s && !scl_d;
    assign fall  = !scl_s && scl_d;

    // byte engine: sample on clock rise, change drive on clock fall
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state    <= SER_IDLE;
            sh       <= 8'h00;
            tx       <= 8'h00;
            cnt      <= 4'h0;
            rw       <= 1'b0;
            nack     <= 1'b0;
            o_ptr    <= 8'h00;
            o_wdata  <= 8'h00;
            o_wr     <= 1'b0;
            o_sda_oe <= 1'b0;
        end else if (i_clk_en) begin
            o_wr <= 1'b0;
            if (start) begin
                state    <= SER_ADDR;
                cnt      <= 4'h0;
                o_sda_oe <= 1'b0;
            end else if (stop) begin
                state    <= SER_IDLE;
                o_sda_oe <= 1'b0;
            end else if (rise) begin
                if (state == SER_ADDR || state == SER_REG || state == SER_WDATA) begin
                    sh  <= {sh[6:0], sda_s};
                    cnt <= cnt + 4'h1;
                end
                if (state == SER_MACK)
                    nack <= sda_s;
            end else if (fall) begin
                case (state)
                    SER_ADDR: if (cnt == BITS_PER_BYTE) begin
                        if (sh[7:1] == DEV_ADDR) begin
                            rw       <= sh[0];
                            o_sda_oe <= 1'b1;
                            state    <= SER_AACK;
                        end else begin
                            state    <= SER_IDLE;
                        end
                    end
                    SER_AACK: begin
                        cnt <= 4'h0;
                        if (rw) begin
                            tx       <= i_rdata;
                            o_sda_oe <= !i_rdata[7];
                            state    <= SER_RDATA;
                        end else begin
                            o_sda_oe <= 1'b0;
                            state    <= SER_REG;
                        end
                    end
                    SER_REG: if (cnt == BITS_PER_BYTE) begin
                        o_ptr    <= sh;
                        o_sda_oe <= 1'b1;
                        state    <= SER_RACKW;
                    end
                    SER_RACKW, SER_WACK: begin
                        o_sda_oe <= 1'b0;
                        cnt      <= 4'h0;
                        state    <= SER_WDATA;
                        if (state == SER_WACK)
                            o_ptr <= o_ptr + 8'h01;
                    end
                    SER_WDATA: if (cnt == BITS_PER_BYTE) begin
                        o_wdata  <= sh;
                        o_wr     <= 1'b1;
                        o_sda_oe <= 1'b1;
                        state    <= SER_WACK;
                    end
                    SER_RDATA: begin
                        if (cnt == LAST_TX_BIT) begin
                            o_sda_oe <= 1'b0;    // let the master acknowledge
                            o_ptr    <= o_ptr + 8'h01;
                            state    <= SER_MACK;
                        end else begin
                            tx       <= {tx[6:0], 1'b0};
                            o_sda_oe <= !tx[6];
                            cnt      <= cnt + 4'h1;
                        end
                    end
                    SER_MACK: begin
                        cnt <= 4'h0;
                        if (nack) begin
                            state <= SER_IDLE;
                        end else begin
                            tx       <= i_rdata;
                            o_sda_oe <= !i_rdata[7];
                            state    <= SER_RDATA;
                        end
                    end
                    default: state <= SER_IDLE;
                endcase
            end
        end
    end

endmodule // serial_reg_port

// ==== rtl/charger_control_status_regs.sv ====
// Purpose: charger configuration, status and charge-enable hold logic
// Assumes: sense levels come from analog comparators and the charger core
// Notes:   host reaches the registers over the two-wire serial port only
module charger_control_status_regs
    import charger_regs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_clk_en,
    // serial pins, data is open drain
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    // analog and charger core levels
    input  wire sense_s     i_sense,
    // controls to the charger and power path
    output cfg_s            o_cfg,
    output logic [2:0]      o_current_quarters,
    output logic            o_charge_voltage_safety,
    output logic            o_status_event
);
    sense_s      sense_m, sense;
    cfg_s        cfg;
    stat_s       stat;
    logic [7:0]  gpio_three_and_charge_voltage_safety;
    logic [7:0]  ptr, wdata, rdata;
    logic        wr;
    logic        uvlo_d, uvlo_rise, uvlo_fall;
    logic        ce_latch, latch_en, power, eff_ce;
    logic [1:0]  next_state_code;

    serial_reg_port #(
        .DEV_ADDR (DEV_ADDR)
    ) u_port (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_clk_en (i_clk_en),
        .i_scl    (i_scl),
        .i_sda    (i_sda),
        .o_sda_oe (o_sda_oe),
        .i_rdata  (rdata),
        .o_ptr    (ptr),
        .o_wdata  (wdata),
        .o_wr     (wr)
    );

    // open drain: only ever pulls low
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst)
            o_sda_out <= 1'b0;
        else
            o_sda_out <= 1'b0;
    end

    // sense levels cross in from analog, two flops before use
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sense_m <= '0;
            sense   <= '0;
            uvlo_d  <= 1'b0;
        end else if (i_clk_en) begin
            sense_m <= i_sense;
            sense   <= sense_m;
            uvlo_d  <= sense.out_uvlo;
        end
    end

    assign uvlo_rise = sense.out_uvlo && !uvlo_d;
    assign uvlo_fall = !sense.out_uvlo && uvlo_d;
    assign power     = sense.wall_input_present || sense.usb_input_present;

    // configuration register; the undervoltage reset beats a host write
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg <= cfg_s'(CFG_RESET);
        end else if (i_clk_en) begin
            if (wr && ptr == ADDR_CFG)
                cfg <= cfg_s'(wdata);
            if (uvlo_rise)
                cfg.system_from_input <= CE_DEFAULT;
        end
    end

    // gpio-shared register, only bit four reaches the charger
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst)
            gpio_three_and_charge_voltage_safety <= GPIO_THREE_AND_CHARGE_VOLTAGE_SAFETY_RESET;
        else if (i_clk_en && wr && ptr == ADDR_GPIO_THREE_AND_CHARGE_VOLTAGE_SAFETY)
            gpio_three_and_charge_voltage_safety <= wdata;
    end

    // charge-enable hold; power loss wins over a capture in the same cycle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ce_latch <= LATCH_RESET;
            latch_en <= 1'b0;
        end else if (i_clk_en) begin
            if (!power)
                ce_latch <= LATCH_RESET;
            else if (uvlo_rise)
                ce_latch <= cfg.system_from_input;
            if (uvlo_rise)
                latch_en <= 1'b1;
            else if (uvlo_fall)
                latch_en <= 1'b0;
        end
    end

    // held value steers switches only while held, in lockout and powered
    assign eff_ce = (latch_en && sense.out_uvlo && power) ? ce_latch
                                                          : cfg.system_from_input;

    // charge state encode; disabled, faulted, unpowered or idle reads as off, done reads as done
    always_comb begin
        if (!cfg.charge_run || sense.fault || !power)
            next_state_code = ST_OFF;
        else if (sense.done)
            next_state_code = ST_DONE;
        else if (sense.fast)
            next_state_code = ST_FAST;
        else if (sense.precharge)
            next_state_code = ST_PRE;
        else
            next_state_code = ST_OFF;
    end

    // status register; supplement flag has hysteresis between two comparators
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stat <= '0;
        end else if (i_clk_en) begin
            if (sense.sup_enter)
                stat.supplement_flag <= 1'b1;
            else if (sense.sup_exit)
                stat.supplement_flag <= 1'b0;
            stat.selected_input_flag    <= sense.selected_input_flag;
            stat.loop_active_flag       <= sense.loop_active_flag;
            stat.wall_input_present     <= sense.wall_input_present;
            stat.usb_input_present      <= sense.usb_input_present;
            {stat.charge_state_hi, stat.charge_state_lo} <= next_state_code;
            stat.input_overvoltage_flag <= sense.input_overvoltage_flag;
        end
    end

    // change pulse ignores the supplement flag so it can chatter freely
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_status_event <= 1'b0;
        end else if (i_clk_en) begin
            o_status_event <= (stat[6:0] != {sense.selected_input_flag, sense.loop_active_flag,
                               sense.wall_input_present, sense.usb_input_present,
                               next_state_code, sense.input_overvoltage_flag});
        end
    end

    // read mux; status is stale without input power, left to host software
    always_comb begin
        case (ptr)
            ADDR_CFG:   rdata = cfg;
            ADDR_STAT:  rdata = stat;
            ADDR_GPIO_THREE_AND_CHARGE_VOLTAGE_SAFETY: rdata = gpio_three_and_charge_voltage_safety;
            default:    rdata = 8'h00;
        endcase
    end

    // registered controls to the analog side
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_cfg                   <= cfg_s'(CFG_RESET);
            o_current_quarters      <= 3'h4;
            o_charge_voltage_safety <= GPIO_THREE_AND_CHARGE_VOLTAGE_SAFETY_RESET[BIT_SAFETY];
        end else if (i_clk_en) begin
            o_cfg                   <= cfg;
            o_cfg.system_from_input <= eff_ce;
            o_current_quarters      <= {1'b0, cfg.charge_current_scale} + 3'h1;
            o_charge_voltage_safety <= gpio_three_and_charge_voltage_safety[BIT_SAFETY];
        end
    end

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_uvlo_entry;
        i_clk_en && uvlo_rise;
    endsequence

    sequence s_uvlo_exit;
        i_clk_en && uvlo_fall;
    endsequence

    a_scale_quarters: assert property (i_clk_en |=>
        o_current_quarters == {1'b0, $past(cfg.charge_current_scale)} + 3'h1)
        else $error("current scale output wrong");
    a_state_done: assert property (i_clk_en && power && cfg.charge_run && !sense.fault && sense.done |=>
        {stat.charge_state_hi, stat.charge_state_lo} == ST_DONE)
        else $error("done state code wrong");
    a_state_off: assert property (i_clk_en && !cfg.charge_run |=>
        {stat.charge_state_hi, stat.charge_state_lo} == ST_OFF)
        else $error("off state code wrong");
    a_uvlo_capture: assert property (s_uvlo_entry ##0 power |=>
        ce_latch == $past(cfg.system_from_input) && cfg.system_from_input == CE_DEFAULT && latch_en)
        else $error("enable not captured on lockout");
    a_latch_steers: assert property (latch_en && sense.out_uvlo && power |-> eff_ce == ce_latch)
        else $error("held enable not in control");
    a_latch_clear: assert property (i_clk_en && !power |=> ce_latch == LATCH_RESET)
        else $error("held enable kept without power");
    a_latch_hold: assert property (i_clk_en && power && !uvlo_rise |=> $stable(ce_latch))
        else $error("held enable changed unexpectedly");
    a_uvlo_release: assert property (s_uvlo_exit |=> !latch_en ##0 eff_ce == cfg.system_from_input)
        else $error("control not returned on lockout exit");
    a_supp_hyst: assert property (i_clk_en && sense.sup_exit && !sense.sup_enter |=> !stat.supplement_flag)
        else $error("supplement flag did not clear");
    a_supp_masked: assert property (i_clk_en ##1 $changed(stat.supplement_flag) && $stable(stat[6:0])
        |-> !o_status_event)
        else $error("supplement flag raised an event");
    a_safety_bit: assert property (i_clk_en |=> o_charge_voltage_safety == $past(gpio_three_and_charge_voltage_safety[BIT_SAFETY]))
        else $error("safety bit not forwarded");

endmodule // charger_control_status_regs

// ==== tb/i2c_host_model.sv ====
// Purpose: host side of the two-wire register port
// Assumes: data line has a pull-up, its wire level comes back on i_sda
// Notes:   scl low is two steps and scl high one step of five clocks, above the four-clock minimum
module i2c_host_model
    import charger_regs_pkg::*;
(
    // clock
    input  wire logic       i_clk,
    // data line level
    input  wire logic       i_sda,
    // host pins
    output logic            o_scl,
    output logic            o_sda_pull,
    // read results
    output logic [7:0]      o_rd_data,
    output logic            o_rd_valid
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus: both lines released
    initial begin
        o_scl      = 1'b1;
        o_sda_pull = 1'b0;
        o_rd_data  = 8'h00;
        o_rd_valid = 1'b0;
    end

    task automatic step();
        repeat (5) @(posedge i_clk);
    endtask

    // data moves only mid low phase, so it never looks like start or stop
    task automatic put_bit(input logic b, output logic seen);
        step();
        o_sda_pull <= ~b; // open drain: pull only for a zero
        step();
        o_scl <= 1'b1;
        step();
        seen = i_sda; // late in the high phase, past the sync lag
        o_scl <= 1'b0;
    endtask

    // release data first, then clock, so a repeated start is clean
    task automatic start();
        o_sda_pull <= 1'b0;
        step();
        o_scl <= 1'b1;
        step();
        o_sda_pull <= 1'b1;
        step();
        o_scl <= 1'b0;
    endtask

    task automatic stop();
        step();
        o_sda_pull <= 1'b1;
        step();
        o_scl <= 1'b1;
        step();
        o_sda_pull <= 1'b0;
        step();
    endtask

    task automatic send_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, s); // let the device answer
    endtask

    task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
        start();
        send_byte({DEV_ADDR_DEFAULT, 1'b0});
        send_byte(p);
        send_byte(d);
        stop();
    endtask

    // pointer set by a write, then one byte read and refused with a nack
    task automatic read_reg(input logic [7:0] p);
        logic [7:0] d;
        logic       s;
        start();
        send_byte({DEV_ADDR_DEFAULT, 1'b0});
        send_byte(p);
        start();
        send_byte({DEV_ADDR_DEFAULT, 1'b1});
        for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
        put_bit(1'b1, s);
        stop();
        o_rd_data  <= d;
        o_rd_valid <= 1'b1;
        @(posedge i_clk);
        o_rd_valid <= 1'b0;
    endtask
endmodule // i2c_host_model

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the charger register block
// Assumes: host model owns the serial pins, bench owns the sense levels
// Notes:   read results are checked against a queue of expected bytes
module tb_top
    import charger_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk;
    logic       nrst;
    logic       clk_en;
    logic       scl;
    logic       sda_pull;
    logic       sda_oe;
    logic       sda_out;
    wire logic  sda;
    logic [7:0] rd_data;
    logic       rd_valid;
    sense_s     sense;
    cfg_s       cfg;
    logic [2:0] quarters;
    logic       safety;
    logic       status_event;
    int         mismatches;
    int         comparisons;
    int         ev_count;
    logic [7:0] exp_q[$];
    logic [7:0] v;
    logic [7:0] st;
    logic [3:0] r;
    logic [3:0] flags[5] = '{4'b1000, 4'b1110, 4'b1010, 4'b0011, 4'b0000};
    logic [1:0] codes[5] = '{ST_PRE, ST_DONE, ST_FAST, ST_OFF, ST_OFF};

    // pull-up wins unless someone pulls low; the device's level counts only while it drives
    assign sda = ~sda_pull & (~sda_oe | sda_out);

    always #10 clk = ~clk;

    charger_control_status_regs i_dut (
        .i_clk                  (clk),
        .i_nrst                 (nrst),
        .i_clk_en               (clk_en),
        .i_scl                  (scl),
        .i_sda                  (sda),
        .o_sda_out              (sda_out),
        .o_sda_oe               (sda_oe),
        .i_sense                (sense),
        .o_cfg                  (cfg),
        .o_current_quarters     (quarters),
        .o_charge_voltage_safety(safety),
        .o_status_event         (status_event)
    );

    i2c_host_model i_host (
        .i_clk     (clk),
        .i_sda     (sda),
        .o_scl     (scl),
        .o_sda_pull(sda_pull),
        .o_rd_data (rd_data),
        .o_rd_valid(rd_valid)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic test_done();
        $display("counts: comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // status pulses counted so a scenario can ask how many it saw
    always @(posedge clk) begin
        if (status_event === 1'b1) ev_count++;
    end

    // each read byte is matched with the oldest expectation
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) check(rd_data, 8'hxx);
            else check(rd_data, exp_q.pop_front());
        end
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        test_done();
    end

    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] p, input logic [7:0] want);
        exp_q.push_back(want);
        i_host.read_reg(p);
    endtask

    initial begin
        clk    = 1'b0;
        nrst   = 1'b0;
        clk_en = 1'b1;
        sense  = '0;
        void'($urandom(32'ha64439da));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        settle();
        check(cfg, CFG_RESET);
        check({5'h0, quarters}, 8'h04);
        check({7'h0, safety}, 8'h00);
        $display("reset values done");
        // every scale code, other bits random, enable kept off
        for (int s = 0; s < 4; s++) begin
            v      = 8'($urandom());
            v[4:3] = s[1:0];
            v[0]   = 1'b0;
            i_host.write_reg(ADDR_CFG, v);
            settle();
            check({5'h0, quarters}, 8'(s + 1));
            check(cfg, v);
            rd(ADDR_CFG, v);
        end
        v = 8'($urandom());
        i_host.write_reg(ADDR_GPIO_THREE_AND_CHARGE_VOLTAGE_SAFETY, v);
        settle();
        check({7'h0, safety}, {7'h0, v[BIT_SAFETY]});
        rd(ADDR_GPIO_THREE_AND_CHARGE_VOLTAGE_SAFETY, v);
        rd(8'h30, 8'h00);
        $display("config and safety done");
        // charge states with wall power applied, status read only then
        i_host.write_reg(ADDR_CFG, CFG_RESET);
        i_host.write_reg(ADDR_STAT, 8'hff); // read-only, ignored
        for (int k = 0; k < 5; k++) begin
            r        = 4'($urandom());
            ev_count = 0;
            sense    <= {2'b00, r[0], r[1], 1'b1, r[2], r[3], 1'b0, flags[k]};
            settle();
            if (k == 0) check(8'(ev_count > 0), 8'h01);
            st = {1'b0, r[0], r[1], 1'b1, r[2], codes[k], r[3]};
            rd(ADDR_STAT, st);
        end
        $display("charge states done");
        // supplement flag: set, hold, clear, never an event
        ev_count = 0;
        sense.sup_enter <= 1'b1;
        settle();
        sense.sup_enter <= 1'b0;
        settle();
        check(ev_count[7:0], 8'h00);
        rd(ADDR_STAT, st | 8'h80);
        sense.sup_exit <= 1'b1;
        settle();
        rd(ADDR_STAT, st);
        check(ev_count[7:0], 8'h00);
        sense.sup_exit <= 1'b0;
        $display("supplement done");
        // lockout with power present, then power lost and restored during lockout
        i_host.write_reg(ADDR_CFG, 8'h59);
        settle();
        check({7'h0, cfg.system_from_input}, 8'h01);
        sense.out_uvlo <= 1'b1;
        settle();
        rd(ADDR_CFG, 8'h58);
        i_host.write_reg(ADDR_CFG, 8'h58);
        settle();
        check({7'h0, cfg.system_from_input}, 8'h01);
        sense.out_uvlo <= 1'b0;
        settle();
        check({7'h0, cfg.system_from_input}, 8'h00);
        i_host.write_reg(ADDR_CFG, 8'h59);
        settle();
        check({7'h0, cfg.system_from_input}, 8'h01);
        sense.out_uvlo <= 1'b1;
        settle();
        sense.wall_input_present <= 1'b0;
        sense.usb_input_present  <= 1'b0; // usb may still be up from the state loop
        settle();
        sense.wall_input_present <= 1'b1;
        settle();
        check({7'h0, cfg.system_from_input}, 8'h00);
        $display("lockout done");
        settle();
        if (exp_q.size() != 0) check(8'(exp_q.size()), 8'h00);
        test_done();
    end
endmodule // tb_top
